// >>> rtl/drpp_postproc.sv
// drpp_postproc.sv: distance post-processing with AXI4-Lite register access
// assumes samples arrive on aclk as one-cycle strobes at least 80 cycles apart
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`include "drpp_regs.svh"

module drpp_postproc #(
  parameter int DW = 16,
  parameter int MED_MAX = 21,
  parameter int AVG_MAX = 256,
  parameter int TICK_CYC = `DRPP_TICK_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // samples from the measurement engine
  input wire logic smp_valid,
  input wire logic [DW-1:0] smp_dist,
  input wire logic smp_in_range,
  input wire logic smp_quality_ok,
  // results
  output logic res_strobe,
  output logic [DW-1:0] dist_out,
  output logic dist_nan,
  output logic [15:0] aout_code,
  output logic sw_out,
  output logic led_yellow,
  output logic alarm
);

  localparam int RW = $clog2(MED_MAX + 1);
  localparam int PW = $clog2(AVG_MAX);
  localparam int LW = PW + 1;
  localparam int SW = DW + LW;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] med_len(input logic [2:0] p, input logic [4:0] c);
    unique case (p)
      drpp_pkg::DRPP_PRE_STD: med_len = 5'h00;
      drpp_pkg::DRPP_PRE_HIGH, drpp_pkg::DRPP_PRE_VHIGH,
      drpp_pkg::DRPP_PRE_HIGHEST: med_len = `DRPP_MED_PRE;
      drpp_pkg::DRPP_PRE_CUSTOM: med_len = (c > `DRPP_MED_LIM) ? `DRPP_MED_LIM : c;
      default: med_len = 5'h00;
    endcase
  endfunction : med_len

  function automatic logic [8:0] avg_len(input logic [2:0] p, input logic [8:0] c);
    unique case (p)
      drpp_pkg::DRPP_PRE_STD, drpp_pkg::DRPP_PRE_HIGH: avg_len = 9'h000;
      drpp_pkg::DRPP_PRE_VHIGH: avg_len = `DRPP_AVG_VH;
      drpp_pkg::DRPP_PRE_HIGHEST: avg_len = `DRPP_AVG_HI;
      drpp_pkg::DRPP_PRE_CUSTOM: avg_len = (c > `DRPP_AVG_LIM) ? `DRPP_AVG_LIM : c;
      default: avg_len = 9'h000;
    endcase
  endfunction : avg_len

  // fraction of the field onto the selected output range
  function automatic logic [15:0] ana_map(input logic [15:0] q, input logic [1:0] t,
                                          input logic inv);
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] qq;
    logic [31:0] prod;
    lo = (t == 2'h2) ? `DRPP_AO_LO_I20 : (t == 2'h3) ? `DRPP_AO_LO_I10 :
         (t == 2'h1) ? `DRPP_AO_LO_V5 : `DRPP_AO_LO_V10;
    hi = (t == 2'h2) ? `DRPP_AO_HI_I20 : (t == 2'h3) ? `DRPP_AO_HI_I10 :
         (t == 2'h1) ? `DRPP_AO_HI_V5 : `DRPP_AO_HI_V10;
    qq = inv ? ~q : q;
    // one extra step of range lets a full fraction land exactly on hi
    prod = qq * (hi - lo) + 32'(hi - lo);
    ana_map = lo + prod[31:16];
  endfunction : ana_map

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
  endfunction : merge

  function automatic logic [31:0] cfg_rst(input int i);
    if (i == 5)
      cfg_rst = `DRPP_SPAN_END;
    else if (i == 4)
      cfg_rst = `DRPP_SPAN_BEG;
    else
      cfg_rst = 32'h0000_0000;
  endfunction : cfg_rst

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic aw_ok_q, w_ok_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] cfg_q [`DRPP_NCFG];
  logic [31:0] setup_q [`DRPP_NSETUP][`DRPP_NSAVE];
  logic sw_st_q;

  // write decode; status and analog readback are read-only
  wire [3:0] wr_ix = awaddr_q[5:2];
  wire wr_fire = aw_ok_q & w_ok_q & ~bvalid;
  wire wr_hit = (awaddr_q[7:6] == 2'h0) && (wr_ix <= `DRPP_R_CMD);
  wire cfg_we = wr_fire & wr_hit & (wr_ix != `DRPP_R_CMD);
  wire cmd_we = wr_fire & wr_hit & (wr_ix == `DRPP_R_CMD);
  wire [1:0] set_ix = wdata_q[`DRPP_F_SETIX];
  wire set_ok = cmd_we & (set_ix < 2'h3);
  wire [3:0] rd_ix = araddr[5:2];
  wire rd_hit = (araddr[7:6] == 2'h0) && (rd_ix != `DRPP_R_CMD);
  wire [31:0] status_w = {13'h0000, sw_st_q, alarm, ~dist_nan, 16'(dist_out)};
  wire [31:0] rd_val = (rd_ix < `DRPP_R_CMD) ? cfg_q[rd_ix] :
                       (rd_ix == `DRPP_R_STATUS) ? status_w :
                       (rd_ix == `DRPP_R_AOUT) ? {16'h0000, aout_code} : 32'h0000_0000;

  // write channel: address and data taken in either order, one at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      {aw_ok_q, w_ok_q, bvalid} <= 3'h0;
      {awready, wready} <= 2'h3;
      bresp <= `DRPP_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready)
      begin
        aw_ok_q <= 1'b1;
        awready <= 1'b0;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_ok_q <= 1'b1;
        wready <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? `DRPP_RESP_OKAY : `DRPP_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        {bvalid, aw_ok_q, w_ok_q} <= 3'h0;
        {awready, wready} <= 2'h3;
      end
    end
  end

  // read channel: one beat, data registered with the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `DRPP_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_hit ? rd_val : 32'h0000_0000;
      rresp <= rd_hit ? `DRPP_RESP_OKAY : `DRPP_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // configuration words; commands act after the plain write
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      for (int i = 0; i < `DRPP_NCFG; i++)
        cfg_q[i] <= cfg_rst(i);
    end else begin
      if (cfg_we)
        cfg_q[wr_ix] <= merge(cfg_q[wr_ix], wdata_q, wstrb_q);
      if (cmd_we && wdata_q[`DRPP_B_TBG])
        cfg_q[`DRPP_R_TBG] <= 32'(dist_out);
      if (cmd_we && wdata_q[`DRPP_B_TREF])
        cfg_q[`DRPP_R_TREF] <= 32'(dist_out);
      if (cmd_we && wdata_q[`DRPP_B_MAXIM])
      begin
        cfg_q[`DRPP_R_AMIN] <= `DRPP_SPAN_BEG;
        cfg_q[`DRPP_R_AMAX] <= `DRPP_SPAN_END;
      end
      if (set_ok && wdata_q[`DRPP_B_LOAD])
        for (int i = 0; i < `DRPP_NSAVE; i++)
          cfg_q[i] <= setup_q[set_ix][i];
      if (cmd_we && wdata_q[`DRPP_B_TRST])
        for (int i = `DRPP_R_TBG; i <= `DRPP_R_TCTRL; i++)
          cfg_q[i] <= 32'h0000_0000;
    end
  end

  // retained setups are storage, untouched by reset
  always_ff @(posedge aclk)
  begin
    if (set_ok && wdata_q[`DRPP_B_SAVE])
      for (int i = 0; i < `DRPP_NSAVE; i++)
        setup_q[set_ix][i] <= cfg_q[i];
  end

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  wire [2:0] preset = cfg_q[`DRPP_R_FILT][`DRPP_F_PRESET];
  wire [4:0] m_len = med_len(preset, cfg_q[`DRPP_R_FILT][`DRPP_F_MEDLEN]);
  wire [8:0] a_len = avg_len(preset, cfg_q[`DRPP_R_FILT][`DRPP_F_AVGLEN]);
  wire [4:0] m_eff = (m_len <= 5'h01) ? 5'h01 : m_len;
  wire [LW-1:0] a_eff = (a_len <= 9'h001) ? LW'(1) : LW'(a_len);
  wire [1:0] drop_sel = cfg_q[`DRPP_R_OUTCFG][`DRPP_F_DROP];
  wire [1:0] otype = cfg_q[`DRPP_R_OUTCFG][`DRPP_F_OTYPE];
  wire inv = cfg_q[`DRPP_R_OUTCFG][`DRPP_B_INV];
  wire win = cfg_q[`DRPP_R_OUTCFG][`DRPP_B_WIN];
  wire act_low = cfg_q[`DRPP_R_OUTCFG][`DRPP_B_ALOW];
  wire [15:0] hold = cfg_q[`DRPP_R_HOLD][15:0];
  wire [DW-1:0] zero = cfg_q[`DRPP_R_ZERO][DW-1:0];
  wire [DW-1:0] amin = cfg_q[`DRPP_R_AMIN][DW-1:0];
  wire [DW-1:0] amax = cfg_q[`DRPP_R_AMAX][DW-1:0];

  // ----------------------------------------------------------------
  // median and average windows
  // ----------------------------------------------------------------
  drpp_pkg::drpp_state_type st_q;
  logic [DW-1:0] mwin_q [MED_MAX];
  logic [RW-1:0] mfill_q;
  logic [DW-1:0] abuf_q [AVG_MAX];
  logic [PW-1:0] aptr_q;
  logic [LW-1:0] afill_q;
  logic [SW-1:0] asum_q;
  logic [4:0] mlen_prev_q;
  logic [LW-1:0] alen_prev_q;
  logic [DW-1:0] med_val;
  logic [MED_MAX-1:0] msel;

  wire smp_bad = ~smp_in_range | ~smp_quality_ok;
  wire take = (st_q == drpp_pkg::DRPP_IDLE) & smp_valid;
  wire len_chg = (m_eff != mlen_prev_q) || (a_eff != alen_prev_q);
  wire [RW-1:0] m_mid = RW'((mfill_q - RW'(1)) >> 1);

  // rank of each window entry; ties broken by age
  genvar gi;
  for (gi = 0; gi < MED_MAX; gi++)
  begin : g_rank
    logic [RW-1:0] rk;
    always_comb
    begin
      rk = '0;
      for (int j = 0; j < MED_MAX; j++)
        if (j < mfill_q && (mwin_q[j] < mwin_q[gi] || (mwin_q[j] == mwin_q[gi] && j < gi)))
          rk = rk + RW'(1);
    end
    assign msel[gi] = (gi < mfill_q) && (rk == m_mid);
  end

  // pick the entry of middle rank
  always_comb
  begin
    med_val = '0;
    for (int i = 0; i < MED_MAX; i++)
      if (msel[i])
        med_val = mwin_q[i];
  end

  // running sum: the oldest sample leaves as the new one enters
  wire evict = afill_q >= a_eff;
  wire [PW-1:0] old_ix = aptr_q - PW'(a_eff);
  wire [SW-1:0] sum_new = asum_q + SW'(med_val) - (evict ? SW'(abuf_q[old_ix]) : SW'(0));
  wire [LW-1:0] a_n = evict ? a_eff : afill_q + LW'(1);

  // windows restart whenever a length changes, so no stale mix leaks out
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      mfill_q <= '0;
      afill_q <= '0;
      asum_q <= '0;
      aptr_q <= '0;
      mlen_prev_q <= 5'h01;
      alen_prev_q <= LW'(1);
    end else if (len_chg) begin
      {mfill_q, afill_q, asum_q} <= '0;
      mlen_prev_q <= m_eff;
      alen_prev_q <= a_eff;
    end else if (take && !smp_bad) begin
      for (int i = MED_MAX - 1; i > 0; i--)
        mwin_q[i] <= mwin_q[i-1];
      mwin_q[0] <= smp_dist;
      if (mfill_q < RW'(m_eff))
        mfill_q <= mfill_q + RW'(1);
    end else if (st_q == drpp_pkg::DRPP_MED) begin
      abuf_q[aptr_q] <= med_val;
      aptr_q <= aptr_q + PW'(1);
      asum_q <= sum_new;
      afill_q <= a_n;
    end
  end

  // ----------------------------------------------------------------
  // shared sequential divider
  // ----------------------------------------------------------------
  logic [31:0] dnum_q;
  logic [15:0] drem_q;
  logic [15:0] dden_q;
  logic [5:0] dcnt_q;
  logic [DW-1:0] rel_q;

  // rel is the filtered distance seen from the zero position
  wire [DW-1:0] filt = dnum_q[DW-1:0];
  wire [DW-1:0] rel_w = (filt >= zero) ? filt - zero : '0;
  wire div_idle = dcnt_q == 6'h00;
  wire adiv_done = (st_q == drpp_pkg::DRPP_DIVA) & div_idle;
  wire bdiv_done = (st_q == drpp_pkg::DRPP_DIVB) & div_idle;
  wire div_go = (st_q == drpp_pkg::DRPP_MED) | adiv_done;
  wire [31:0] div_num = (st_q == drpp_pkg::DRPP_MED) ? 32'(sum_new) :
                        {16'(rel_w - amin), 16'h0000};
  wire [15:0] div_den = (st_q == drpp_pkg::DRPP_MED) ? 16'(a_n) :
                        (amax > amin) ? 16'(amax - amin) : 16'h0001;
  wire [16:0] rem_sh = {drem_q, dnum_q[31]};
  wire rem_ge = rem_sh >= {1'b0, dden_q};
  wire [16:0] rem_sub = rem_sh - {1'b0, dden_q};

  // restoring division, one quotient bit per cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      dcnt_q <= 6'h00;
      dnum_q <= 32'h0000_0000;
      drem_q <= 16'h0000;
      dden_q <= 16'h0001;
    end else if (div_go) begin
      dnum_q <= div_num;
      dden_q <= div_den;
      drem_q <= 16'h0000;
      dcnt_q <= 6'h20;
    end else if (!div_idle) begin
      drem_q <= rem_ge ? rem_sub[15:0] : rem_sh[15:0];
      dnum_q <= {dnum_q[30:0], rem_ge};
      dcnt_q <= dcnt_q - 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      st_q <= drpp_pkg::DRPP_IDLE;
      rel_q <= '0;
    end else begin
      unique case (st_q)
        drpp_pkg::DRPP_IDLE: if (take && !smp_bad && !len_chg) st_q <= drpp_pkg::DRPP_MED;
        drpp_pkg::DRPP_MED: st_q <= drpp_pkg::DRPP_DIVA;
        drpp_pkg::DRPP_DIVA:
          if (div_idle)
          begin
            rel_q <= rel_w;
            st_q <= drpp_pkg::DRPP_DIVB;
          end
        drpp_pkg::DRPP_DIVB: if (div_idle) st_q <= drpp_pkg::DRPP_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // analog, switching and dropout
  // ----------------------------------------------------------------
  logic [TICK_CYC > 1 ? $clog2(TICK_CYC) - 1 : 0 : 0] tick_cnt_q;
  logic tick_q;
  logic drop_q;
  logic [15:0] hold_cnt_q;

  // field fraction clamped at both output points
  wire [15:0] frac = (rel_q <= amin) ? 16'h0000 :
                     (rel_q >= amax) ? 16'hFFFF : dnum_q[15:0];
  wire signed [17:0] hs = 18'(signed'(cfg_q[`DRPP_R_HYST][15:0]));
  wire signed [17:0] hp = (hs > 0) ? hs : 18'sh0;
  wire signed [17:0] hn = (hs < 0) ? -hs : 18'sh0;
  wire signed [17:0] d = 18'(rel_q);
  wire signed [17:0] sp = 18'(cfg_q[`DRPP_R_SWPT][15:0]);
  wire signed [17:0] fr = 18'(cfg_q[`DRPP_R_SWFAR][15:0]);
  // point: on at or below the point; window: on inside near..far
  wire sw_set = win ? (d >= sp + hn && d <= fr - hn) : (d <= sp - hn);
  wire sw_clr = win ? (d < sp - hp || d > fr + hp) : (d > sp + hp);
  wire sw_nx = sw_set ? 1'b1 : sw_clr ? 1'b0 : sw_st_q;
  wire expire = drop_q & ~alarm & (hold_cnt_q >= hold);
  wire bad_take = take & smp_bad;

  // millisecond tick for the hold time
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tick_cnt_q == $bits(tick_cnt_q)'(TICK_CYC - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= aresetn;
    end else begin
      tick_cnt_q <= tick_cnt_q + $bits(tick_cnt_q)'(1);
      tick_q <= 1'b0;
    end
  end

  // dropout tracking: a valid result ends it, a fresh dropout restarts the wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn || bdiv_done) begin
      drop_q <= 1'b0;
      alarm <= 1'b0;
      hold_cnt_q <= 16'h0000;
    end else if (bad_take && !drop_q) begin
      drop_q <= 1'b1;
      hold_cnt_q <= 16'h0000;
    end else if (expire) begin
      alarm <= 1'b1;
    end else if (drop_q && !alarm && tick_q) begin
      hold_cnt_q <= hold_cnt_q + 16'h0001;
    end
  end

  // result registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      res_strobe <= 1'b0;
      dist_out <= '0;
      dist_nan <= 1'b1;
      aout_code <= `DRPP_AO_LO_V10;
      sw_st_q <= 1'b0;
      sw_out <= 1'b0;
      led_yellow <= 1'b0;
    end else begin
      res_strobe <= bdiv_done | bad_take;
      sw_out <= sw_st_q ^ act_low;
      led_yellow <= sw_st_q ^ act_low;
      if (bdiv_done)
      begin
        dist_out <= rel_q;
        dist_nan <= 1'b0;
        aout_code <= ana_map(frac, otype, inv);
        sw_st_q <= sw_nx;
      end
      if (bad_take)
        dist_nan <= 1'b1;
      if (expire && drop_sel == drpp_pkg::DRPP_DROP_NEAR)
        aout_code <= ana_map(16'h0000, otype, inv);
      else if (expire && drop_sel == drpp_pkg::DRPP_DROP_FAR)
        aout_code <= ana_map(16'hFFFF, otype, inv);
    end
  end

endmodule : drpp_postproc

// >>> rtl/drpp_regs.svh
// drpp_regs.svh: register indices, field positions, reset values and timing counts
// assumes AXI4-Lite access, one aligned 32-bit word per register, byte address = index * 4
`ifndef DRPP_REGS_SVH
`define DRPP_REGS_SVH

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define DRPP_R_FILT 4'h0
`define DRPP_R_OUTCFG 4'h1
`define DRPP_R_HOLD 4'h2
`define DRPP_R_ZERO 4'h3
`define DRPP_R_AMIN 4'h4
`define DRPP_R_AMAX 4'h5
`define DRPP_R_SWPT 4'h6
`define DRPP_R_SWFAR 4'h7
`define DRPP_R_HYST 4'h8
`define DRPP_R_TBG 4'h9
`define DRPP_R_TREF 4'hA
`define DRPP_R_THGT 4'hB
`define DRPP_R_TCTRL 4'hC
`define DRPP_R_CMD 4'hD
`define DRPP_R_STATUS 4'hE
`define DRPP_R_AOUT 4'hF
`define DRPP_NCFG 13
`define DRPP_NSAVE 9
`define DRPP_NSETUP 3

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define DRPP_F_PRESET 2:0
`define DRPP_F_MEDLEN 12:8
`define DRPP_F_AVGLEN 24:16
`define DRPP_F_DROP 1:0
`define DRPP_F_OTYPE 5:4
`define DRPP_B_INV 8
`define DRPP_B_WIN 12
`define DRPP_B_ALOW 16
`define DRPP_B_TEN 0
`define DRPP_B_MAXIM 0
`define DRPP_B_TRST 1
`define DRPP_B_TBG 2
`define DRPP_B_TREF 3
`define DRPP_F_SETIX 5:4
`define DRPP_B_SAVE 6
`define DRPP_B_LOAD 7

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define DRPP_MED_PRE 5'h09
`define DRPP_AVG_VH 9'h010
`define DRPP_AVG_HI 9'h080
`define DRPP_MED_LIM 5'h15
`define DRPP_AVG_LIM 9'h100
`define DRPP_SPAN_BEG 32'h0000_0000
`define DRPP_SPAN_END 32'h0000_FFFF
`define DRPP_AO_LO_V10 16'h0000
`define DRPP_AO_HI_V10 16'hFFFF
`define DRPP_AO_LO_V5 16'h0000
`define DRPP_AO_HI_V5 16'h7FFF
`define DRPP_AO_LO_I20 16'h3333
`define DRPP_AO_HI_I20 16'hFFFF
`define DRPP_AO_LO_I10 16'h1999
`define DRPP_AO_HI_I10 16'h7FFF
`define DRPP_RESP_OKAY 2'h0
`define DRPP_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DRPP_CLK_PS 5000
`define DRPP_HOLD_UNIT_NS 1000000
`define DRPP_TICK_CYC ((`DRPP_HOLD_UNIT_NS * 1000) / `DRPP_CLK_PS)

`endif

// >>> rtl/drpp_pkg.sv
// drpp_pkg.sv: types of the distance post-processor
// assumes drpp_regs.svh carries every number but the preset and dropout encodings held here
package drpp_pkg;

  // processing sequence
  typedef enum {DRPP_IDLE, DRPP_MED, DRPP_DIVA, DRPP_DIVB} drpp_state_type;

  // filter presets as held in the filter register
  typedef enum logic [2:0] {
    DRPP_PRE_STD = 3'h0,
    DRPP_PRE_HIGH = 3'h1,
    DRPP_PRE_VHIGH = 3'h2,
    DRPP_PRE_HIGHEST = 3'h3,
    DRPP_PRE_CUSTOM = 3'h4
  } drpp_preset_type;

  // analog level after dropout
  typedef enum logic [1:0] {
    DRPP_DROP_NEAR = 2'h0,
    DRPP_DROP_FAR = 2'h1,
    DRPP_DROP_LAST = 2'h2
  } drpp_drop_type;

endpackage : drpp_pkg

// >>> sim/drpp_engine_model.sv
// drpp_engine_model.sv: upstream measurement engine, one sample per send call
// assumes the post-processor's aclk; the caller keeps samples far enough apart
module drpp_engine_model (
  // clock
  input wire logic aclk,
  // sample stream
  output logic smp_valid,
  output logic [15:0] smp_dist,
  output logic smp_in_range,
  output logic smp_quality_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle stream at time zero
  initial
  begin
    smp_valid = 1'b0;
    smp_dist = 16'h0000;
    smp_in_range = 1'b0;
    smp_quality_ok = 1'b0;
  end

  // one-cycle strobe; the distance is stale afterwards, so show its inverse
  task automatic send(input logic [15:0] d, input logic r, input logic q);
    @(posedge aclk);
    smp_valid <= 1'b1;
    smp_dist <= d;
    smp_in_range <= r;
    smp_quality_ok <= q;
    @(posedge aclk);
    smp_valid <= 1'b0;
    smp_dist <= ~d;
  endtask : send
endmodule : drpp_engine_model

// >>> sim/drpp_postproc_checker.sv
// drpp_postproc_checker.sv: port-level assertions for the post-processor
// assumes one aclk domain and the synchronous active-low aresetn
module drpp_postproc_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid,
  // results
  input wire logic res_strobe, dist_nan, sw_out, led_yellow, alarm,
  input wire logic [15:0] aout_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_wr_ans; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  property p_rd_ans; arvalid && arready |=> rvalid; endproperty
  property p_pulse; res_strobe |=> !res_strobe; endproperty
  property p_nan_hold; !res_strobe |-> $stable(dist_nan); endproperty
  property p_sw_keep; res_strobe && dist_nan |=> $stable(sw_out) [*2]; endproperty
  property p_led; led_yellow == sw_out; endproperty
  property p_alarm; $rose(alarm) |-> dist_nan && $past(dist_nan); endproperty
  // hold time keeps the analog level until the alarm fires
  property p_aout_hold; dist_nan && !alarm && !res_strobe |-> $stable(aout_code); endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  a_rd_ans: assert property (p_rd_ans) else $error("read response late");
  a_pulse: assert property (p_pulse) else $error("result strobe too long");
  a_nan_hold: assert property (p_nan_hold) else $error("nan flag moved");
  a_sw_keep: assert property (p_sw_keep) else $error("switch moved on invalid");
  a_led: assert property (p_led) else $error("led differs from switch");
  a_alarm: assert property (p_alarm) else $error("alarm without dropout");
  a_aout_hold: assert property (p_aout_hold) else $error("analog moved in hold");
  c_valid: cover property (res_strobe && !dist_nan);
  c_alarm: cover property ($rose(alarm));
  c_sw: cover property ($rose(sw_out));
endmodule : drpp_postproc_checker

bind drpp_postproc drpp_postproc_checker chk_i (.aclk, .aresetn, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .res_strobe, .dist_nan,
  .sw_out, .led_yellow, .alarm, .aout_code);

// >>> sim/drpp_postproc_tb.sv
// drpp_postproc_tb.sv: register and sample scenarios for the post-processor
// assumes the engine model as sample source and a shortened hold tick
module drpp_postproc_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, smp_valid, smp_in_range, smp_quality_ok;
  logic res_strobe, dist_nan, sw_out, led_yellow, alarm;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] smp_dist, dist_out, aout_code;
  logic [15:0] lo [4] = '{16'h0000, 16'h0000, 16'h3333, 16'h1999};
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  drpp_postproc #(.TICK_CYC(10)) uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .smp_valid, .smp_dist, .smp_in_range, .smp_quality_ok,
    .res_strobe, .dist_out, .dist_nan, .aout_code, .sw_out, .led_yellow, .alarm);
  drpp_engine_model m (.aclk, .smp_valid, .smp_dist, .smp_in_range, .smp_quality_ok);

  // ----------------------------------------------------------------
  // clock, hang guard and tasks
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // about 1700 cycles expected, so a hang shows well before this ceiling
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", 32'h0, bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
  endtask : rd

  // one sample, then wait for its result and let the switch settle
  task automatic smp(input logic [15:0] d, input logic r, input logic q);
    m.send(d, r, q);
    for (int i = 0; i < 200 && res_strobe !== 1'b1; i++) @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask : smp

  // main sequence
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    aresetn = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h14, 32'h0000FFFF, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h00, 32'h00020104);
    smp(16'h1000, 1'b1, 1'b1);
    chk("dist", 16'h1000, dist_out);
    smp(16'h2000, 1'b1, 1'b1);
    chk("dist", 16'h1800, dist_out);
    smp(16'h2000, 1'b1, 1'b1);
    chk("dist", 16'h2000, dist_out);
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h100);
    smp(16'h1100, 1'b1, 1'b1);
    chk("dist", 16'h1000, dist_out);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h1000);
    wr(8'h14, 32'h2000);
    for (int t = 0; t < 4; t++)
    begin
      wr(8'h04, t << 4);
      smp(16'h0800, 1'b1, 1'b1);
      chk("aout", lo[t], aout_code);
    end
    wr(8'h04, 32'h100);
    smp(16'h0800, 1'b1, 1'b1);
    chk("aout", 16'hFFFF, aout_code);
    wr(8'h18, 32'h1000);
    wr(8'h20, 32'h10);
    wr(8'h04, 32'h0);
    smp(16'h0FF0, 1'b1, 1'b1);
    chk("sw", 1'b1, sw_out);
    smp(16'h1008, 1'b1, 1'b1);
    chk("sw", 1'b1, sw_out);
    smp(16'h1020, 1'b1, 1'b1);
    chk("sw", 1'b0, sw_out);
    wr(8'h08, 32'h3);
    wr(8'h04, 32'h10001);
    smp(16'h0800, 1'b1, 1'b1);
    chk("sw", 1'b0, sw_out);
    smp(16'h0900, 1'b1, 1'b0);
    chk("nan", 1'b1, dist_nan);
    chk("alarm", 1'b0, alarm);
    smp(16'h0900, 1'b0, 1'b1);
    chk("aout", 16'h0000, aout_code);
    repeat (60) @(posedge aclk);
    chk("alarm", 1'b1, alarm);
    chk("aout", 16'hFFFF, aout_code);
    chk("sw", 1'b0, sw_out);
    // window mode, active high, near dropout
    wr(8'h04, 32'h1000);
    wr(8'h1C, 32'h2000);
    smp(16'h2100, 1'b1, 1'b1);
    chk("sw", 1'b0, sw_out);
    chk("alarm", 1'b0, alarm);
    smp(16'h1800, 1'b1, 1'b1);
    chk("sw", 1'b1, sw_out);
    chk("aout", 16'h8000, aout_code);
    smp(16'h2008, 1'b1, 1'b1);
    chk("sw", 1'b1, sw_out);
    // median of three rejects a single spike
    wr(8'h00, 32'h00010304);
    smp(16'h1000, 1'b1, 1'b1);
    smp(16'h1000, 1'b1, 1'b1);
    smp(16'hF000, 1'b1, 1'b1);
    chk("dist", 16'h1000, dist_out);
    wr(8'h34, 32'h1);
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h14, 32'h0000FFFF, 2'h0);
    wr(8'h24, 32'h55);
    wr(8'h30, 32'h1);
    rd(8'h24, 32'h55, 2'h0);
    wr(8'h34, 32'h2);
    rd(8'h24, 32'h0, 2'h0);
    rd(8'h30, 32'h0, 2'h0);
    wr(8'h34, 32'h40);
    wr(8'h18, 32'h0);
    wr(8'h34, 32'h80);
    rd(8'h18, 32'h1000, 2'h0);
    stop_test();
  end
endmodule : drpp_postproc_tb
